// ===== include/adc_defs.svh
// Register offsets, field positions, reset values and counts of the converter control.
`ifndef ADC_DEFS_SVH
`define ADC_DEFS_SVH

`define OFS_CTRL 8'h00
`define OFS_DATA 8'h04
`define OFS_CLK 8'h08
`define OFS_PORT_OUT 8'h0C
`define OFS_PORT_DIR 8'h10
`define OFS_PORT_IN 8'h14

`define CTRL_DONE_BIT 7
`define CTRL_IRQ_BIT 6
`define CTRL_CONT_BIT 5
`define CTRL_CHAN_HI 4
`define CLK_DIV_HI 7
`define CLK_DIV_LO 5
`define CLK_SRC_BIT 4

`define CTRL_RST 7'h1F
`define DIV_RST 3'h0
`define SRC_RST 1'h0
`define PORT_RST 6'h00

`define CH_PINS 5'h06
`define CH_REFH 5'h1D
`define CH_REFL 5'h1E
`define CH_OFF 5'h1F

`define CONV_LAST 4'hF
`define BIT_LAST 4'h8
`define TRIAL_START 8'h80
`define DIV16_LAST 4'hF
`define DIV_UNIT 4'h1

`define RESP_OK 2'h0
`define RESP_ERR 2'h2

`endif

// ===== include/adc_pkg.sv
// Types shared by the converter control, the analog front end model and the bench.
package adc_pkg;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_SETTLE = 3'b010,
		ST_CONV = 3'b100
	} conv_state_t;

	typedef struct packed {
		logic irq_en;
		logic cont;
		logic [4:0] chan;
	} conv_ctrl_t;

	typedef struct packed {
		logic power_on;
		logic sample;
		logic [4:0] chan;
		logic [7:0] trial;
	} analog_drive_t;

endpackage

// ===== hdl/adc_clock_divider.sv
// Prescaler that turns the selected input clock into converter clock ticks.
`timescale 1ns/1ps
`default_nettype none
`include "adc_defs.svh"

module adc_clock_divider (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_n,
	// Input clock ticks and ratio.
	input wire logic clear,
	input wire logic in_tick,
	input wire logic [2:0] prescale,
	// Converter clock tick.
	output logic tick
);
	logic [3:0] cnt_ff;
	logic [3:0] last;

	// Top bit set means divide by 16 whatever the low bits are.
	assign last = prescale[2] ? `DIV16_LAST : 4'((`DIV_UNIT << prescale[1:0]) - `DIV_UNIT);
	assign tick = in_tick && (cnt_ff == last);

	always_ff @(posedge clk) begin
		if (!rst_n || clear || tick) begin
			cnt_ff <= 4'h0;
		end else if (in_tick) begin
			cnt_ff <= 4'(cnt_ff + `DIV_UNIT);
		end
	end

endmodule
`default_nettype wire

// ===== hdl/sar_adc_conversion_control.sv
// Successive-approximation converter control with an AXI4-Lite register slave.
//
// Our own choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "adc_defs.svh"

module sar_adc_conversion_control (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_n,
	// AXI4-Lite write address and data.
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	// AXI4-Lite write response.
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// AXI4-Lite read.
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Clock source, comparator and stop mode.
	input wire logic osc_tick,
	input wire logic comp_in,
	input wire logic stop_mode,
	// Analog front end drive and interrupt.
	output adc_pkg::analog_drive_t analog_drive,
	output logic irq,
	// Shared port pins.
	input wire logic [5:0] pin_in,
	output logic [5:0] pin_out,
	output logic [5:0] pin_oe
);
	import adc_pkg::*;

	function automatic logic [5:0] pin_mask(input logic [4:0] ch);
		pin_mask = (ch < `CH_PINS) ? (6'h01 << ch) : 6'h00;
	endfunction

	function automatic logic addr_ok(input logic [7:0] a);
		addr_ok = (a == `OFS_CTRL) || (a == `OFS_DATA) || (a == `OFS_CLK) ||
			(a == `OFS_PORT_OUT) || (a == `OFS_PORT_DIR) || (a == `OFS_PORT_IN);
	endfunction

	conv_ctrl_t ctrl_ff;
	logic done_ff;
	logic irq_ff;
	logic [7:0] result_ff;
	logic [2:0] prescale_ff;
	logic src_bus_ff;
	logic [5:0] port_out_ff;
	logic [5:0] port_dir_ff;
	logic [5:0] pin_out_ff;
	logic [5:0] pin_oe_ff;
	analog_drive_t analog_ff;

	logic awready_ff;
	logic wready_ff;
	logic bvalid_ff;
	logic [1:0] bresp_ff;
	logic arready_ff;
	logic rvalid_ff;
	logic [1:0] rresp_ff;
	logic [31:0] rdata_ff;
	logic aw_got_ff;
	logic w_got_ff;
	logic [7:0] aw_addr_ff;
	logic [7:0] wdata_ff;
	logic wstrb0_ff;

	conv_state_t state_ff;
	logic [3:0] cnt_ff;
	logic [7:0] trial_ff;
	logic pend_ff;
	logic settle_ff;

	logic wr_fire;
	logic wr_hit;
	logic ctrl_we;
	logic ar_hs;
	logic data_rd;
	logic [31:0] rd_mux;
	logic tick;
	logic powered;
	logic conv_end;
	logic [2:0] bit_idx;

	assign awready = awready_ff;
	assign wready = wready_ff;
	assign bvalid = bvalid_ff;
	assign bresp = bresp_ff;
	assign arready = arready_ff;
	assign rvalid = rvalid_ff;
	assign rresp = rresp_ff;
	assign rdata = rdata_ff;
	assign irq = irq_ff;
	// The comparator sees the trial code straight from its register, so a divide-by-one
	// converter clock still gives it a full cycle to answer the latest trial.
	assign analog_drive = {analog_ff.power_on, analog_ff.sample, analog_ff.chan, trial_ff};
	assign pin_out = pin_out_ff;
	assign pin_oe = pin_oe_ff;

	// The write takes effect once both address and data are held, whatever their order.
	assign wr_fire = aw_got_ff && w_got_ff && !bvalid_ff;
	assign wr_hit = wr_fire && wstrb0_ff;
	assign ctrl_we = wr_hit && (aw_addr_ff == `OFS_CTRL);
	assign ar_hs = arvalid && arready_ff;
	assign data_rd = ar_hs && (araddr == `OFS_DATA);
	assign powered = (ctrl_ff.chan != `CH_OFF);
	assign conv_end = (state_ff == ST_CONV) && tick && (cnt_ff == `CONV_LAST);
	assign bit_idx = 3'(`BIT_LAST - cnt_ff);

	always_comb begin
		case (araddr)
			`OFS_CTRL: rd_mux = {24'h0, done_ff && !ctrl_ff.irq_en, ctrl_ff};
			`OFS_DATA: rd_mux = {24'h0, result_ff};
			`OFS_CLK: rd_mux = {24'h0, prescale_ff, src_bus_ff, 4'h0};
			`OFS_PORT_OUT: rd_mux = {26'h0, port_out_ff};
			`OFS_PORT_DIR: rd_mux = {26'h0, port_dir_ff};
			`OFS_PORT_IN: rd_mux = {26'h0, pin_in & ~pin_mask(ctrl_ff.chan)};
			default: rd_mux = 32'h0;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			awready_ff <= 1'b1;
			wready_ff <= 1'b1;
			aw_got_ff <= 1'b0;
			w_got_ff <= 1'b0;
			bvalid_ff <= 1'b0;
			bresp_ff <= `RESP_OK;
			aw_addr_ff <= 8'h00;
			wdata_ff <= 8'h00;
			wstrb0_ff <= 1'b0;
		end else begin
			if (awvalid && awready_ff) begin
				aw_addr_ff <= awaddr;
				aw_got_ff <= 1'b1;
				awready_ff <= 1'b0;
			end
			if (wvalid && wready_ff) begin
				wdata_ff <= wdata[7:0];
				wstrb0_ff <= wstrb[0];
				w_got_ff <= 1'b1;
				wready_ff <= 1'b0;
			end
			if (wr_fire) begin
				bvalid_ff <= 1'b1;
				bresp_ff <= addr_ok(aw_addr_ff) ? `RESP_OK : `RESP_ERR;
			end
			if (bvalid_ff && bready) begin
				bvalid_ff <= 1'b0;
				aw_got_ff <= 1'b0;
				w_got_ff <= 1'b0;
				awready_ff <= 1'b1;
				wready_ff <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			arready_ff <= 1'b1;
			rvalid_ff <= 1'b0;
			rresp_ff <= `RESP_OK;
			rdata_ff <= 32'h0;
		end else if (ar_hs) begin
			arready_ff <= 1'b0;
			rvalid_ff <= 1'b1;
			rresp_ff <= addr_ok(araddr) ? `RESP_OK : `RESP_ERR;
			rdata_ff <= rd_mux;
		end else if (rvalid_ff && rready) begin
			rvalid_ff <= 1'b0;
			arready_ff <= 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ctrl_ff <= `CTRL_RST;
			prescale_ff <= `DIV_RST;
			src_bus_ff <= `SRC_RST;
			port_out_ff <= `PORT_RST;
			port_dir_ff <= `PORT_RST;
		end else if (wr_hit) begin
			case (aw_addr_ff)
				`OFS_CTRL: ctrl_ff <= wdata_ff[`CTRL_IRQ_BIT:0];
				`OFS_CLK: begin
					prescale_ff <= wdata_ff[`CLK_DIV_HI:`CLK_DIV_LO];
					src_bus_ff <= wdata_ff[`CLK_SRC_BIT];
				end
				`OFS_PORT_OUT: port_out_ff <= wdata_ff[5:0];
				`OFS_PORT_DIR: port_dir_ff <= wdata_ff[5:0];
				default: ;
			endcase
		end
	end

	// The pin picked by the channel field is released from the cycle after the field takes it, whatever the port registers hold.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pin_out_ff <= `PORT_RST;
			pin_oe_ff <= `PORT_RST;
		end else begin
			pin_out_ff <= port_out_ff & ~pin_mask(ctrl_ff.chan);
			pin_oe_ff <= port_dir_ff & ~pin_mask(ctrl_ff.chan);
		end
	end

	adc_clock_divider u_div (
		.clk(clk),
		.rst_n(rst_n),
		.clear(stop_mode || ctrl_we),
		.in_tick(src_bus_ff ? 1'b1 : osc_tick),
		.prescale(prescale_ff),
		.tick(tick)
	);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_ff <= ST_IDLE;
			cnt_ff <= 4'h0;
			trial_ff <= 8'h00;
			pend_ff <= 1'b0;
			settle_ff <= 1'b1;
		end else if (stop_mode) begin
			// Pending work is kept so that it resumes after stop, behind a settling cycle.
			state_ff <= ST_IDLE;
			settle_ff <= 1'b1;
		end else if (ctrl_we) begin
			state_ff <= ST_IDLE;
			pend_ff <= (wdata_ff[`CTRL_CHAN_HI:0] != `CH_OFF);
			settle_ff <= settle_ff || !powered || (wdata_ff[`CTRL_CHAN_HI:0] == `CH_OFF);
		end else if (!powered) begin
			state_ff <= ST_IDLE;
			pend_ff <= 1'b0;
			settle_ff <= 1'b1;
		end else if (tick) begin
			case (state_ff)
				ST_IDLE: begin
					if (pend_ff) begin
						state_ff <= settle_ff ? ST_SETTLE : ST_CONV;
						cnt_ff <= 4'h0;
						trial_ff <= `TRIAL_START;
					end
				end
				ST_SETTLE: begin
					state_ff <= ST_CONV;
					settle_ff <= 1'b0;
					cnt_ff <= 4'h0;
					trial_ff <= `TRIAL_START;
				end
				ST_CONV: begin
					cnt_ff <= 4'(cnt_ff + 4'h1);
					if ((cnt_ff != 4'h0) && (cnt_ff <= `BIT_LAST)) begin
						// Keep the trial bit only if the input is at or above the trial level.
						trial_ff[bit_idx] <= comp_in;
						if (bit_idx != 3'h0) begin
							trial_ff[bit_idx - 3'h1] <= 1'b1;
						end
					end
					if (cnt_ff == `CONV_LAST) begin
						if (ctrl_ff.cont) begin
							trial_ff <= `TRIAL_START;
						end else begin
							state_ff <= ST_IDLE;
							pend_ff <= 1'b0;
						end
					end
				end
				default: state_ff <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			result_ff <= 8'h00;
		end else if (conv_end) begin
			result_ff <= trial_ff;
		end
	end

	// A conversion end in the same cycle as a data read wins; a control write setting the interrupt enable clears.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			done_ff <= 1'b0;
		end else if (conv_end && !ctrl_ff.irq_en && !(ctrl_we && wdata_ff[`CTRL_IRQ_BIT])) begin
			done_ff <= 1'b1;
		end else if (data_rd || ctrl_ff.irq_en || (ctrl_we && wdata_ff[`CTRL_IRQ_BIT])) begin
			done_ff <= 1'b0;
		end
	end

	// The request is a level and nothing here watches wait mode, so it can wake the core.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			irq_ff <= 1'b0;
		end else if (conv_end && ctrl_ff.irq_en) begin
			irq_ff <= 1'b1;
		end else if (data_rd || ctrl_we) begin
			irq_ff <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			analog_ff <= '0;
		end else begin
			analog_ff.power_on <= powered && !stop_mode;
			analog_ff.sample <= (state_ff == ST_CONV) && (cnt_ff == 4'h0);
			analog_ff.chan <= ctrl_ff.chan;
		end
	end

	done_masked_a: assert property (@(posedge clk) disable iff (!rst_n)
		ctrl_ff.irq_en |-> !done_ff)
		else $error("done flag set while interrupts enabled");

	result_load_a: assert property (@(posedge clk) disable iff (!rst_n)
		conv_end |=> result_ff == $past(trial_ff))
		else $error("result not loaded at conversion end");

	pin_release_a: assert property (@(posedge clk) disable iff (!rst_n)
		##1 (pin_oe_ff & pin_mask($past(ctrl_ff.chan))) == 6'h00)
		else $error("selected pin still driven");

	pin_read_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
		ar_hs && (araddr == `OFS_PORT_IN) |=>
		(rdata_ff[5:0] & pin_mask($past(ctrl_ff.chan))) == 6'h00)
		else $error("selected pin reads nonzero");

	single_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
		conv_end && !ctrl_ff.cont && !stop_mode && !ctrl_we && powered
		|=> state_ff == ST_IDLE && !pend_ff)
		else $error("single conversion did not idle");

	cont_restart_a: assert property (@(posedge clk) disable iff (!rst_n)
		conv_end && ctrl_ff.cont && !stop_mode && !ctrl_we && powered
		|=> state_ff == ST_CONV && cnt_ff == 4'h0)
		else $error("continuous mode did not restart");

	done_set_a: assert property (@(posedge clk) disable iff (!rst_n)
		conv_end && !ctrl_ff.irq_en && !(ctrl_we && wdata_ff[`CTRL_IRQ_BIT]) |=> done_ff)
		else $error("done flag not set");

	irq_raise_a: assert property (@(posedge clk) disable iff (!rst_n)
		conv_end && ctrl_ff.irq_en |=> irq_ff)
		else $error("interrupt not raised");

	irq_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
		ctrl_we && !(conv_end && ctrl_ff.irq_en) |=> !irq_ff)
		else $error("interrupt not cleared by control write");

	stop_abort_a: assert property (@(posedge clk) disable iff (!rst_n)
		stop_mode |=> state_ff == ST_IDLE && !analog_ff.power_on)
		else $error("stop did not abort");

	settle_first_a: assert property (@(posedge clk) disable iff (!rst_n)
		$fell(stop_mode) && pend_ff && powered |=> state_ff != ST_CONV)
		else $error("no settling cycle after stop");

endmodule
`default_nettype wire

// ===== verification/analog_front_model.sv
// Behavioural analog front end answering the converter's comparator trials.
`timescale 1ns/1ps
`default_nettype none
module analog_front_model (
	// Clock.
	input wire logic clk,
	// Converter drive and pin levels.
	input wire adc_pkg::analog_drive_t analog_drive,
	input wire logic [47:0] pin_level,
	// Comparator result.
	output logic comp_in
);
	import adc_pkg::*;
	logic [7:0] level;
	logic flip_ff = 1'b0;
	always_comb begin
		case (analog_drive.chan)
			5'h1D: level = 8'hFF;
			5'h1E: level = 8'h00;
			default: level = (analog_drive.chan < 5'h06) ?
				pin_level[{analog_drive.chan[2:0], 3'h0} +: 8] : 8'h5A;
		endcase
	end
	// A powered-down comparator gives no steady answer.
	always_ff @(posedge clk) begin
		flip_ff <= !flip_ff;
	end
	assign comp_in = analog_drive.power_on ? (level >= analog_drive.trial) : flip_ff;
endmodule
`default_nettype wire

// ===== verification/sar_adc_conversion_control_tb.sv
// Self-checking bench for the converter control over its register bus.
`timescale 1ns/1ps
`default_nettype none
`include "adc_defs.svh"
module sar_adc_conversion_control_tb;
	import adc_pkg::*;
	logic clk, rst_n, awvalid, wvalid, bready, arvalid, rready, osc_tick, stop_mode;
	logic awready, wready, bvalid, arready, rvalid, comp_in, irq;
	logic [7:0] awaddr, araddr, lv;
	logic [31:0] wdata, rdata, rd, seed;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, rs;
	logic [5:0] pin_in, pin_out, pin_oe;
	logic [47:0] pin_level;
	logic [4:0] ch;
	analog_drive_t analog_drive;
	int mismatches, checked, n, dv;
	int osc_cnt = 0;

	sar_adc_conversion_control i_dut (.clk(clk), .rst_n(rst_n), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
		.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.osc_tick(osc_tick), .comp_in(comp_in), .stop_mode(stop_mode),
		.analog_drive(analog_drive), .irq(irq), .pin_in(pin_in),
		.pin_out(pin_out), .pin_oe(pin_oe));
	analog_front_model i_afe (.clk(clk), .analog_drive(analog_drive),
		.pin_level(pin_level), .comp_in(comp_in));

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// Oscillator runs at a quarter of the bus clock.
	always @(posedge clk) begin
		osc_cnt <= osc_cnt + 1;
		osc_tick <= (osc_cnt % 4 == 3);
	end

	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction
	function automatic int divof(input logic [2:0] p);
		return p[2] ? 16 : (1 << p[1:0]);
	endfunction
	function automatic logic [7:0] lvl_of(input logic [4:0] c);
		return c == `CH_REFH ? 8'hFF : c == `CH_REFL ? 8'h00 : pin_level[{c[2:0], 3'h0} +: 8];
	endfunction

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %s expected %0h seen %0h", what, exp, got);
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic aw_done;
		logic w_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (!(aw_done && w_done)) begin
			@(posedge clk);
			if (!aw_done && awready) begin
				aw_done = 1'b1;
				awvalid <= 1'b0;
			end
			if (!w_done && wready) begin
				w_done = 1'b1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge clk); while (!bvalid);
		rs = bresp;
	endtask
	task automatic rdr(input logic [7:0] a);
		araddr <= a;
		arvalid <= 1'b1;
		do @(posedge clk); while (!arready);
		arvalid <= 1'b0;
		do @(posedge clk); while (!rvalid);
		rd = rdata;
		rs = rresp;
	endtask
	task automatic waitirq();
		n = 0;
		while (irq !== 1'b1) begin
			@(posedge clk);
			n++;
		end
	endtask
	task automatic newlevels();
		seed = xs(seed);
		pin_level <= {seed[15:0], seed};
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	initial begin
		#2000000;
		mismatches++;
		final_report();
	end

	initial begin
		{rst_n, awvalid, wvalid, bready, arvalid, rready, stop_mode} = 7'h0A;
		{awaddr, araddr, wdata, pin_in, pin_level} = '0;
		wstrb = 4'hF;
		osc_tick = 1'b0;
		seed = 32'hF;
		cyc(6);
		rst_n <= 1'b1;
		cyc(1);
		rdr(`OFS_CTRL);
		chk("ctrl reset", 32'h1F, rd);
		rdr(`OFS_CLK);
		chk("clock reset", 32'h0, rd);
		chk("irq reset", 32'h0, irq);
		rdr(8'h40);
		chk("unmapped resp", `RESP_ERR, rs);
		$display("test reset finished");
		for (int i = 0; i < 8; i++) begin
			ch = (i < 6) ? 5'(i) : (i == 6 ? `CH_REFH : `CH_REFL);
			newlevels();
			dv = divof(3'(i));
			wr(`OFS_CLK, {24'h0, 3'(i), 5'h10});
			wr(`OFS_CTRL, {25'h0, 2'b10, ch});
			lv = lvl_of(ch);
			waitirq();
			chk("time low", 32'h1, n >= 16 * dv - 2);
			chk("time high", 32'h1, n <= 17 * dv + 3);
			rdr(`OFS_CTRL);
			chk("done with irq", 32'h0, rd[7]);
			rdr(`OFS_DATA);
			chk("result", lv, rd);
			chk("irq after read", 32'h0, irq);
		end
		$display("test channels and prescale finished");
		wr(`OFS_CLK, 32'h0);
		chk("write resp", `RESP_OK, rs);
		wr(`OFS_CTRL, 32'h42);
		waitirq();
		chk("osc time", 32'h1, n >= 62 && n <= 76);
		rdr(`OFS_DATA);
		chk("osc result", lvl_of(5'h02), rd);
		$display("test oscillator source finished");
		wr(`OFS_CLK, 32'h10);
		wr(`OFS_CTRL, 32'h03);
		cyc(30);
		chk("no irq", 32'h0, irq);
		rdr(`OFS_CTRL);
		chk("done set", 32'h1, rd[7]);
		rdr(`OFS_DATA);
		chk("single result", lvl_of(5'h03), rd);
		rdr(`OFS_CTRL);
		chk("done cleared", 32'h0, rd[7]);
		cyc(60);
		rdr(`OFS_CTRL);
		chk("single idle", 32'h0, rd[7]);
		wr(`OFS_PORT_OUT, 32'h3F);
		wr(`OFS_PORT_DIR, 32'h3F);
		pin_in <= seed[5:0];
		cyc(2);
		chk("pin oe", 32'h37, pin_oe);
		chk("pin out", 32'h37, pin_out);
		rdr(`OFS_PORT_IN);
		chk("pin read", {26'h0, seed[5:0] & 6'h37}, rd);
		$display("test done flag and pins finished");
		wr(`OFS_CTRL, 32'h21);
		cyc(25);
		newlevels();
		cyc(45);
		rdr(`OFS_DATA);
		chk("cont overwrite", lvl_of(5'h01), rd);
		newlevels();
		cyc(45);
		rdr(`OFS_DATA);
		chk("cont again", lvl_of(5'h01), rd);
		wr(`OFS_CTRL, 32'h01);
		cyc(40);
		rdr(`OFS_DATA);
		cyc(60);
		rdr(`OFS_CTRL);
		chk("cont stopped", 32'h0, rd[7]);
		$display("test continuous finished");
		wr(`OFS_CTRL, 32'h42);
		cyc(5);
		stop_mode <= 1'b1;
		cyc(60);
		chk("irq in stop", 32'h0, irq);
		stop_mode <= 1'b0;
		waitirq();
		chk("resume time", 32'h1, n >= 16 && n <= 20);
		wr(`OFS_CTRL, 32'h1F);
		chk("irq after write", 32'h0, irq);
		cyc(1);
		chk("power off", 32'h1F, {analog_drive.power_on, analog_drive.chan});
		$display("test stop mode finished");
		final_report();
	end
endmodule
`default_nettype wire
